//--- hdl/wwd_params.svh
// Register indices, field positions, reset codes and rates of the windowed watchdog
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// ***********************************************
// Register indices on the plain register port
// ***********************************************
`define WWD_IDX_CTRL0     3'h0
`define WWD_IDX_CTRL1     3'h1
`define WWD_IDX_PS_LOW    3'h2
`define WWD_IDX_PS_HIGH   3'h3
`define WWD_IDX_VIEW      3'h4

// ***********************************************
// Field positions
// ***********************************************
`define WWD_SEN_BIT       0
`define WWD_DIV_LSB       1
`define WWD_DIV_MSB       5
`define WWD_CS_LSB        4
`define WWD_CS_MSB        6
`define WWD_WIN_LSB       0
`define WWD_WIN_MSB       2
`define WWD_ARMED_BIT     2

// ***********************************************
// Codes and reset values
// ***********************************************
`define WWD_DIV_OPEN      5'h1f
`define WWD_DIV_DEFAULT   5'h0b
`define WWD_DIV_MAX       5'h12
`define WWD_DIV_MIN       5'h00
`define WWD_CS_OPEN       3'h7
`define WWD_CS_RESET      3'h0
`define WWD_CS_MFO        3'h1
`define WWD_WIN_OPEN      3'h7
`define WWD_CNT_LAST      5'h1f

// ***********************************************
// Nominal time base: 32 ticks of 31 kHz is 1 ms
// ***********************************************
`define WWD_LFO_HZ        31000
`define WWD_MIN_DIV_LOG2  5

`endif

//--- hdl/wwd_pkg.sv
// Types shared by the windowed watchdog modules
package wwd_pkg;

	// Operating mode from the configuration word
	typedef enum logic [1:0] {
		WWD_MODE_OFF   = 2'b00,
		WWD_MODE_SOFT  = 2'b01,
		WWD_MODE_AWAKE = 2'b10,
		WWD_MODE_ON    = 2'b11
	} wwd_mode_t;

	// State of one oscillator pin synchroniser
	typedef struct packed {
		logic s1;  // First stage, read only by s2
		logic s2;  // Second stage
		logic s3;  // Edge history
		logic tick; // Registered rising edge
	} wwd_sync_t;

	// Whole state of the watchdog core
	typedef struct packed {
		logic        init;      // Config defaults loaded
		logic [4:0]  div;       // Time-out divider select
		logic        soft_enable;       // Soft enable
		logic [2:0]  cs;        // Clock source select
		logic [2:0]  win;       // Window select
		logic [17:0] ps;        // Prescale counter
		logic [4:0]  cnt;       // Watchdog counter
		logic        armed;     // Armed for a clear
		logic        sleep_d;   // Sleep level last cycle
		logic [7:0]  rdata;     // Read data
		logic        dog_rst;   // Reset request pulse
		logic        viol;      // Window violation pulse
		logic        wake;      // Sleep time-out pulse
	} wwd_state_t;

endpackage : wwd_pkg

//--- hdl/wwd_osc_tick.sv
// Two-flop synchroniser with rising-edge tick for an oscillator pin
`timescale 1ns/1ps
`include "wwd_params.svh"

module wwd_osc_tick
	import wwd_pkg::*;
(
	input  wire logic clk,     // System clock
	input  wire logic arst_n,  // Async reset
	input  wire logic osc_pin, // Oscillator from outside
	output logic      tick     // One-cycle pulse per rising edge
);

	wwd_sync_t s_q;  // Registered state
	wwd_sync_t s_d;  // Next state

	// ***********************************************
	// Next state
	// ***********************************************
	always_comb begin
		s_d      = s_q;
		s_d.s1   = osc_pin;
		s_d.s2   = s_q.s1;
		s_d.s3   = s_q.s2;
		s_d.tick = s_q.s2 & ~s_q.s3; // Edge seen past the second stage only
	end

	// Registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule : wwd_osc_tick

//--- hdl/wwd_window_cmp.sv
// Window comparator: closed while elapsed eighths are below the delay
`timescale 1ns/1ps
`include "wwd_params.svh"

module wwd_window_cmp
	import wwd_pkg::*;
(
	input  wire logic [2:0] win,     // Window select code
	input  wire logic [4:0] cnt,     // Watchdog counter
	output logic            closed   // Window closed now
);

	logic [2:0] delay8; // Closed delay in eighths of the period

	// Delay is seven eighths at code 0, none at code 7
	always_comb begin
		delay8 = 3'h7 - win;
		closed = (cnt[4:2] < delay8);
	end

endmodule : wwd_window_cmp

//--- hdl/wwd_core.sv
// Windowed watchdog control registers, counters, window and clear logic
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "wwd_params.svh"

// How it works
// - Divider field picks 1:32 doubling to 1:8388608
// - Divider codes above 10010 act as 1:32
// - Divider resets to 01011 or config value
// - Divider writable only with config all ones
// - Soft enable acts only in mode 01
// - Clock select: 000 slow, 001 medium oscillator
// - Clock select resets 000 or config value, writable only config 111
// - Window code sets opening in eighths
// - Window resets from config, writable only 111
// - Eighteen-bit prescaler readable over three registers
// - View bits 7:3 show watchdog counter
// - View bit 2 shows armed flag
// - Readback counters read-only, zero after reset
// - Unimplemented bits read zero, ignore writes
// - Period from divider on selected oscillator ticks
// - Control writes clear counter and prescaler
// - Clear without arming read is a violation when window is not 111
// - Clear in closed window resets device
// - Time-out in sleep wakes instead of resetting
module wwd_core
	import wwd_pkg::*;
(
	input  wire logic       clk,          // 40 MHz system clock
	input  wire logic       arst_n,       // Async reset, active low
	input  wire logic [1:0] cfg_mode,     // Config operating mode
	input  wire logic [4:0] cfg_div,      // Config divider field
	input  wire logic [2:0] cfg_clk,      // Config clock field
	input  wire logic [2:0] cfg_win,      // Config window field
	input  wire logic       lfo_pin,      // Slow oscillator
	input  wire logic       mfo_pin,      // Medium oscillator
	input  wire logic       sleep,        // Core asleep
	input  wire logic       clr_dog,      // Clear instruction pulse
	input  wire logic [2:0] addr,         // Register index
	input  wire logic [7:0] wdata,        // Write data
	input  wire logic       wr,           // Write strobe
	input  wire logic       rd,           // Read strobe
	output logic      [7:0] rdata,        // Read data, cycle after rd
	output logic            dog_reset,    // Reset request pulse
	output logic            viol_pulse,   // Window violation pulse
	output logic            wake_pulse    // Sleep time-out pulse
);

	// ***********************************************
	// Declarations
	// ***********************************************
	wwd_state_t  s_q;        // Registered state
	wwd_state_t  s_d;        // Next state
	wwd_mode_t   mode;       // Decoded mode
	logic        lfo_tick;   // Slow oscillator edge
	logic        mfo_tick;   // Medium oscillator edge
	logic        tick;       // Selected time base edge
	logic        closed;     // Window closed
	logic        en;         // Watchdog running
	logic [4:0]  eff_div;    // Effective divider code
	logic [18:0] ps_mask;    // Prescaler wrap value
	logic        ps_wrap;    // Prescaler at wrap
	logic        wr_ctrl;    // Write to a control register
	logic        windowed;   // Window smaller than whole
	logic        clr_ok;     // Accepted clear
	logic        clr_bad;    // Violating clear
	logic        timeout;    // Counter overflow
	logic        clear_all;  // Clear counters
	logic [7:0]  rd_mux;     // Read data selection

	// ***********************************************
	// Time base and window
	// ***********************************************
	wwd_osc_tick u_lfo (
		.clk     (clk),
		.arst_n  (arst_n),
		.osc_pin (lfo_pin),
		.tick    (lfo_tick)
	);

	wwd_osc_tick u_mfo (
		.clk     (clk),
		.arst_n  (arst_n),
		.osc_pin (mfo_pin),
		.tick    (mfo_tick)
	);

	wwd_window_cmp u_win (
		.win    (s_q.win),
		.cnt    (s_q.cnt),
		.closed (closed)
	);

	// ***********************************************
	// Decode of mode, divider and events
	// ***********************************************
	always_comb begin
		mode = wwd_mode_t'(cfg_mode);
		// Enable by mode
		case (mode)
			WWD_MODE_ON:    en = s_q.init;
			WWD_MODE_AWAKE: en = s_q.init & ~sleep;
			WWD_MODE_SOFT:  en = s_q.init & s_q.soft_enable;
			default:        en = 1'b0;
		endcase
		// Reserved codes fall back to the smallest divider
		eff_div = (s_q.div > `WWD_DIV_MAX) ? `WWD_DIV_MIN : s_q.div;
		// Prescaler spans 2^code ticks, counter multiplies that by 32 steps
		ps_mask = (19'h1 << eff_div) - 19'h1;
		ps_wrap = ({1'b0, s_q.ps} == ps_mask);
		// Medium oscillator at 001, slow one otherwise
		tick = (s_q.cs == `WWD_CS_MFO) ? mfo_tick : lfo_tick;
		wr_ctrl  = wr & ((addr == `WWD_IDX_CTRL0) | (addr == `WWD_IDX_CTRL1));
		windowed = (s_q.win != `WWD_WIN_OPEN);
		// A windowed clear needs arming and an open window
		clr_bad = en & clr_dog & windowed & (~s_q.armed | closed);
		clr_ok  = en & clr_dog & ~clr_bad;
		timeout = en & tick & ps_wrap & (s_q.cnt == `WWD_CNT_LAST);
		clear_all = ~en | (sleep != s_q.sleep_d) | wr_ctrl | clr_ok
			| clr_bad | timeout;
	end

	// ***********************************************
	// Read data selection
	// ***********************************************
	always_comb begin
		rd_mux = 8'h00;
		case (addr)
			`WWD_IDX_CTRL0: begin
				// Bits 7:6 stay zero
				rd_mux[`WWD_DIV_MSB:`WWD_DIV_LSB] = s_q.div;
				rd_mux[`WWD_SEN_BIT] = s_q.soft_enable;
			end
			`WWD_IDX_CTRL1: begin
				// Bits 7 and 3 stay zero
				rd_mux[`WWD_CS_MSB:`WWD_CS_LSB]   = s_q.cs;
				rd_mux[`WWD_WIN_MSB:`WWD_WIN_LSB] = s_q.win;
			end
			`WWD_IDX_PS_LOW: begin
				rd_mux = s_q.ps[7:0];
			end
			`WWD_IDX_PS_HIGH: begin
				rd_mux = s_q.ps[15:8];
			end
			`WWD_IDX_VIEW: begin
				rd_mux = {s_q.cnt, s_q.armed, s_q.ps[17:16]};
			end
			default: begin
				rd_mux = 8'h00;  // Unmapped index reads zero
			end
		endcase
	end

	// ***********************************************
	// Next state
	// ***********************************************
	always_comb begin
		s_d         = s_q;
		s_d.sleep_d = sleep;
		s_d.dog_rst = 1'b0;
		s_d.viol    = 1'b0;
		s_d.wake    = 1'b0;
		s_d.rdata   = rd ? rd_mux : 8'h00;
		if (!s_q.init) begin
			// First cycle after reset: take config defaults
			s_d.init = 1'b1;
			s_d.div  = (cfg_div == `WWD_DIV_OPEN) ? `WWD_DIV_DEFAULT : cfg_div;
			s_d.cs   = (cfg_clk == `WWD_CS_OPEN) ? `WWD_CS_RESET : cfg_clk;
			s_d.win  = cfg_win;
			s_d.soft_enable  = 1'b0;
		end else begin
			// Control writes, locked fields keep their value
			if (wr && (addr == `WWD_IDX_CTRL0)) begin
				if (cfg_div == `WWD_DIV_OPEN) begin
					s_d.div = wdata[`WWD_DIV_MSB:`WWD_DIV_LSB];
				end
				s_d.soft_enable = wdata[`WWD_SEN_BIT];
			end
			if (wr && (addr == `WWD_IDX_CTRL1)) begin
				if (cfg_clk == `WWD_CS_OPEN) begin
					s_d.cs = wdata[`WWD_CS_MSB:`WWD_CS_LSB];
				end
				if (cfg_win == `WWD_WIN_OPEN) begin
					s_d.win = wdata[`WWD_WIN_MSB:`WWD_WIN_LSB];
				end
			end
		end
		// Counters
		if (clear_all) begin
			s_d.ps    = 18'h0;
			s_d.cnt   = 5'h0;
			s_d.armed = 1'b0;
		end else begin
			if (tick) begin
				if (ps_wrap) begin
					s_d.ps  = 18'h0;
					s_d.cnt = s_q.cnt + 5'h1;
				end else begin
					s_d.ps = s_q.ps + 18'h1;
				end
			end
			// Reading control 0 arms the watchdog
			if (rd && (addr == `WWD_IDX_CTRL0) && en) begin
				s_d.armed = 1'b1;
			end
		end
		// Outcomes
		if (clr_bad) begin
			s_d.dog_rst = 1'b1;
			s_d.viol    = 1'b1;
		end
		if (timeout) begin
			if (sleep) begin
				s_d.wake = 1'b1;
			end else begin
				s_d.dog_rst = 1'b1;
			end
		end
	end

	// ***********************************************
	// Registers, all zero at reset
	// ***********************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state
	assign rdata      = s_q.rdata;
	assign dog_reset  = s_q.dog_rst;
	assign viol_pulse = s_q.viol;
	assign wake_pulse = s_q.wake;

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_write_clears: assert property (
		s_q.init && wr_ctrl |=> (s_q.ps == 18'h0) && (s_q.cnt == 5'h0)
	) else $error("control write did not clear counters");

	chk_div_locked: assert property (
		s_q.init && wr && addr == `WWD_IDX_CTRL0 && cfg_div != `WWD_DIV_OPEN
		|=> $stable(s_q.div)
	) else $error("locked divider changed on write");

	chk_cs_locked: assert property (
		s_q.init && wr && addr == `WWD_IDX_CTRL1 && cfg_clk != `WWD_CS_OPEN
		|=> $stable(s_q.cs)
	) else $error("locked clock select changed on write");

	chk_win_locked: assert property (
		s_q.init && wr && addr == `WWD_IDX_CTRL1 && cfg_win != `WWD_WIN_OPEN
		|=> $stable(s_q.win)
	) else $error("locked window changed on write");

	chk_read_arms: assert property (
		en && rd && addr == `WWD_IDX_CTRL0 && !clear_all |=> s_q.armed
	) else $error("arming read did not arm");

	chk_viol_reset: assert property (
		en && clr_dog && windowed && closed |=> dog_reset && viol_pulse
		##1 !dog_reset
	) else $error("closed-window clear gave no single reset pulse");

	chk_sleep_wake: assert property (
		wake_pulse |-> $past(sleep) && !dog_reset && $past(s_q.cnt) == `WWD_CNT_LAST
	) else $error("wake without sleep time-out");

	chk_view_read: assert property (
		rd && addr == `WWD_IDX_VIEW
		|=> rdata == {$past(s_q.cnt), $past(s_q.armed), $past(s_q.ps[17:16])}
	) else $error("view register read wrong");

	chk_unimpl_zero: assert property (
		rd && addr == `WWD_IDX_CTRL1 |=> rdata[7] == 1'b0 && rdata[3] == 1'b0
		##1 rdata == 8'h00 || $past(rd)
	) else $error("unimplemented bits not zero");

	chk_off_idle: assert property (
		s_q.init && mode == WWD_MODE_OFF |=> s_q.cnt == 5'h0 && !dog_reset
	) else $error("watchdog ran while off");

	// Open divider config loads the two-second default
	chk_div_default: assert property (
		!s_q.init && cfg_div == `WWD_DIV_OPEN |=> s_q.div == `WWD_DIV_DEFAULT
	) else $error("divider default not loaded");

	// Locked divider config loads its own code
	chk_div_config: assert property (
		!s_q.init && cfg_div != `WWD_DIV_OPEN |=> s_q.div == $past(cfg_div)
	) else $error("divider not loaded from config");

	// Reserved divider codes never let the prescaler rise
	chk_div_reserved: assert property (
		s_q.init && s_q.div > `WWD_DIV_MAX && !clear_all
		|=> s_q.ps == 18'h0
	) else $error("reserved divider moved the prescaler");

	// Soft enable always starts off
	chk_sen_reset: assert property (
		!s_q.init |=> !s_q.soft_enable
	) else $error("soft enable not zero after reset");

	// Open clock config starts on the slow oscillator
	chk_cs_default: assert property (
		!s_q.init && cfg_clk == `WWD_CS_OPEN |=> s_q.cs == `WWD_CS_RESET
	) else $error("clock select default wrong");

	// Window select starts from the config field
	chk_win_default: assert property (
		!s_q.init |=> s_q.win == $past(cfg_win)
	) else $error("window not loaded from config");

	// Top two bits of control 0 read as zero
	chk_ctrl0_unimpl: assert property (
		rd && addr == `WWD_IDX_CTRL0 |=> rdata[7:6] == 2'b00
	) else $error("control 0 unimplemented bits not zero");

	// Mode 01 with soft enable low keeps the dog still
	chk_soft_gate: assert property (
		s_q.init && mode == WWD_MODE_SOFT && !s_q.soft_enable
		|=> s_q.cnt == 5'h0 && !dog_reset
	) else $error("watchdog ran with soft enable low");

	// Elapsed eighths plus window code below seven is closed
	chk_closed_viol: assert property (
		en && clr_dog && windowed
		&& ({1'b0, s_q.cnt[4:2]} + {1'b0, s_q.win} < 4'h7)
		|=> viol_pulse
	) else $error("clear in closed window not flagged");

	// Whole-period window never flags a clear
	chk_open_clear: assert property (
		en && clr_dog && !windowed |=> !viol_pulse
	) else $error("clear flagged with window fully open");

	// Awake time-out resets, never wakes
	chk_timeout_reset: assert property (
		timeout && !sleep |=> dog_reset && !wake_pulse
	) else $error("awake time-out gave no reset");

endmodule : wwd_core

//--- tb/wwd_osc_model.sv
// Far-side model: slow and medium oscillators feeding the watchdog time base
`timescale 1ns/1ps

module wwd_osc_model (
	input  wire logic       clk,      // Bench clock, paces the pins
	input  wire logic [7:0] lfo_half, // Slow half period in clocks, 0 stops
	input  wire logic [7:0] mfo_half, // Medium half period in clocks, 0 stops
	output logic            lfo_pin,  // Slow oscillator pin
	output logic            mfo_pin   // Medium oscillator pin
);
	logic [7:0] lfo_cnt; // Slow half-period count
	logic [7:0] mfo_cnt; // Medium half-period count

	// Pins rest low from time zero
	initial begin
		lfo_pin = 1'b0;
		mfo_pin = 1'b0;
		lfo_cnt = 8'h00;
		mfo_cnt = 8'h00;
	end

	// Scaled slow oscillator; a stopped one rests low, no stray edges
	always @(posedge clk) begin
		lfo_cnt <= (lfo_half == 8'h00 || lfo_cnt == lfo_half - 8'h01) ? 8'h00 : lfo_cnt + 8'h01;
		if (lfo_half == 8'h00) lfo_pin <= 1'b0;
		else if (lfo_cnt == lfo_half - 8'h01) lfo_pin <= ~lfo_pin;
	end

	// Medium oscillator, same scheme
	always @(posedge clk) begin
		mfo_cnt <= (mfo_half == 8'h00 || mfo_cnt == mfo_half - 8'h01) ? 8'h00 : mfo_cnt + 8'h01;
		if (mfo_half == 8'h00) mfo_pin <= 1'b0;
		else if (mfo_cnt == mfo_half - 8'h01) mfo_pin <= ~mfo_pin;
	end
endmodule : wwd_osc_model

//--- tb/wwd_core_test.sv
// Self-checking bench for the windowed watchdog registers and time-outs
`timescale 1ns/1ps
`include "wwd_params.svh"

module wwd_core_test;
	logic       clk = 1'b0, arst_n = 1'b0, sleep = 1'b0, clr_dog = 1'b0;
	logic [1:0] cfg_mode = 2'b00;
	logic [4:0] cfg_div = 5'h1f;
	logic [2:0] cfg_clk = 3'h7, cfg_win = 3'h7, addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata, rv;
	logic       wr = 1'b0, rd = 1'b0, lfo_pin, mfo_pin, dog_reset, viol_pulse, wake_pulse;
	logic [7:0] lfo_half = 8'h04, mfo_half = 8'h00; // Pin half periods
	logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1f}; // Divider codes tried
	int         fail_count = 0, comparisons = 0, edges = 0, ev;

	always #12.5 clk = ~clk;
	// Oscillator edges since the last counter clear
	always @(posedge lfo_pin or posedge mfo_pin) edges++;

	wwd_osc_model u_osc (.clk(clk), .lfo_half(lfo_half), .mfo_half(mfo_half),
		.lfo_pin(lfo_pin), .mfo_pin(mfo_pin));
	wwd_core u_dut (.clk(clk), .arst_n(arst_n), .cfg_mode(cfg_mode), .cfg_div(cfg_div),
		.cfg_clk(cfg_clk), .cfg_win(cfg_win), .lfo_pin(lfo_pin), .mfo_pin(mfo_pin),
		.sleep(sleep), .clr_dog(clr_dog), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .dog_reset(dog_reset), .viol_pulse(viol_pulse),
		.wake_pulse(wake_pulse));

	// ***********************************************
	// Bus and compare tasks
	// ***********************************************
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One-cycle write; the edge count restarts with the cleared counters
	task wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
		edges = 0;
	endtask : wr_reg

	// One-cycle read; data taken in the following cycle
	task rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk); addr <= a; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
		@(negedge clk); d = rdata;
	endtask : rd_reg

	task rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
		rd_reg(a, rv);
		check(what, rv, exp);
	endtask : rd_chk

	// Reset with a new configuration, held 8 cycles
	task do_reset(input logic [1:0] m, input logic [4:0] dv, input logic [2:0] cs,
		input logic [2:0] wn, input logic slp);
		@(posedge clk); arst_n <= 1'b0; cfg_mode <= m; cfg_div <= dv;
		cfg_clk <= cs; cfg_win <= wn; sleep <= slp;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		edges = 0;
	endtask : do_reset

	// Clear pulse; answer {viol, reset} one cycle later
	task clr(output logic [7:0] got);
		@(posedge clk); clr_dog <= 1'b1;
		@(posedge clk); clr_dog <= 1'b0;
		@(negedge clk); got = {6'h00, viol_pulse, dog_reset};
	endtask : clr

	// Edges seen when a time-out pulse shows, -1 if none within lim
	task to_check(input string what, input int lim, input int exp);
		int i;
		ev = -1;
		for (i = 0; i < lim; i++) begin
			@(negedge clk);
			if (dog_reset === 1'b1 || wake_pulse === 1'b1) begin
				ev = edges;
				break;
			end
		end
		check(what, {7'h00, ev >= exp - 1 && ev <= exp}, 8'h01);
	endtask : to_check

	task wait_edges(input int n);
		int i;
		for (i = 0; i < 5000 && edges < n; i++) @(posedge clk);
	endtask : wait_edges

	task close_out;
		$display("Totals: %0d comparisons, %0d mismatches", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// Hang guard
	initial begin
		#2ms;
		fail_count++;
		close_out();
	end

	// ***********************************************
	// Test sequence
	// ***********************************************
	initial begin
		// Open configuration: reset values and write masks
		do_reset(2'b00, 5'h1f, 3'h7, 3'h7, 1'b0);
		rd_chk("ctrl0 reset", `WWD_IDX_CTRL0, 8'h16);
		rd_chk("ctrl1 reset", `WWD_IDX_CTRL1, 8'h07);
		rd_chk("ps low reset", `WWD_IDX_PS_LOW, 8'h00);
		rd_chk("ps high reset", `WWD_IDX_PS_HIGH, 8'h00);
		rd_chk("view reset", `WWD_IDX_VIEW, 8'h00);
		wr_reg(`WWD_IDX_CTRL0, 8'hff);
		rd_chk("ctrl0 open", `WWD_IDX_CTRL0, 8'h3f);
		wr_reg(`WWD_IDX_CTRL1, 8'hff);
		rd_chk("ctrl1 open", `WWD_IDX_CTRL1, 8'h77);
		wr_reg(`WWD_IDX_PS_LOW, 8'hff);
		rd_chk("ps low write", `WWD_IDX_PS_LOW, 8'h00);
		rd_chk("unmapped", 3'h5, 8'h00);
		$display("test open registers done");
		// Locked configuration
		do_reset(2'b00, 5'h05, 3'h1, 3'h3, 1'b0);
		rd_chk("ctrl0 locked", `WWD_IDX_CTRL0, 8'h0a);
		wr_reg(`WWD_IDX_CTRL0, 8'h3f);
		rd_chk("ctrl0 lock write", `WWD_IDX_CTRL0, 8'h0b);
		rd_chk("ctrl1 locked", `WWD_IDX_CTRL1, 8'h13);
		wr_reg(`WWD_IDX_CTRL1, 8'h66);
		rd_chk("ctrl1 lock write", `WWD_IDX_CTRL1, 8'h13);
		$display("test locked registers done");
		// Divider codes, reserved ones included
		foreach (codes[k]) begin
			do_reset(2'b11, 5'h1f, 3'h7, 3'h7, 1'b0);
			wr_reg(`WWD_IDX_CTRL0, {2'b00, codes[k], 1'b0});
			to_check("divider", 800, codes[k] > 5'h12 ? 32 : 32 << codes[k]);
		end
		// Prescaler readback on the default divider
		do_reset(2'b11, 5'h1f, 3'h7, 3'h7, 1'b0);
		wait_edges(20);
		rd_reg(`WWD_IDX_PS_LOW, rv);
		check("ps count", {7'h00, rv >= 8'h12 && rv <= 8'h16}, 8'h01);
		rd_chk("ps high count", `WWD_IDX_PS_HIGH, 8'h00);
		rd_chk("view count", `WWD_IDX_VIEW, 8'h00);
		$display("test dividers done");
		// Soft enable and modes
		do_reset(2'b01, 5'h1f, 3'h7, 3'h7, 1'b0);
		wr_reg(`WWD_IDX_CTRL0, 8'h00);
		to_check("soft off", 400, -1);
		wr_reg(`WWD_IDX_CTRL0, 8'h01);
		to_check("soft on", 400, 32);
		do_reset(2'b00, 5'h1f, 3'h7, 3'h7, 1'b0);
		wr_reg(`WWD_IDX_CTRL0, 8'h01);
		to_check("mode off", 400, -1);
		do_reset(2'b10, 5'h00, 3'h7, 3'h7, 1'b1);
		to_check("awake mode asleep", 400, -1);
		do_reset(2'b11, 5'h00, 3'h7, 3'h7, 1'b1);
		to_check("sleep time-out", 400, 32);
		check("sleep wake", {6'h00, wake_pulse, dog_reset}, 8'h02);
		$display("test modes done");
		// Medium oscillator select
		do_reset(2'b11, 5'h00, 3'h7, 3'h7, 1'b0);
		wr_reg(`WWD_IDX_CTRL1, 8'h17);
		to_check("medium idle", 400, -1);
		lfo_half <= 8'h00;
		mfo_half <= 8'h04;
		wr_reg(`WWD_IDX_CTRL1, 8'h17);
		to_check("medium runs", 400, 32);
		lfo_half <= 8'h04;
		mfo_half <= 8'h00;
		$display("test clock select done");
		// Window of one half, divider 1:32
		do_reset(2'b11, 5'h00, 3'h7, 3'h3, 1'b0);
		clr(rv);
		check("unarmed clear", rv, 8'h03);
		do_reset(2'b11, 5'h00, 3'h7, 3'h3, 1'b0);
		rd_reg(`WWD_IDX_CTRL0, rv);
		rd_reg(`WWD_IDX_VIEW, rv);
		check("armed", {7'h00, rv[2]}, 8'h01);
		clr(rv);
		check("closed clear", rv, 8'h03);
		do_reset(2'b11, 5'h00, 3'h7, 3'h3, 1'b0);
		wait_edges(13);
		rd_reg(`WWD_IDX_CTRL0, rv);
		clr(rv);
		check("late closed clear", rv, 8'h03);
		do_reset(2'b11, 5'h00, 3'h7, 3'h3, 1'b0);
		wait_edges(20);
		rd_reg(`WWD_IDX_VIEW, rv);
		check("count view", {7'h00, rv[7:3] >= 5'd18 && rv[7:3] <= 5'd21}, 8'h01);
		rd_reg(`WWD_IDX_CTRL0, rv);
		clr(rv);
		check("open clear", rv, 8'h00);
		rd_reg(`WWD_IDX_VIEW, rv);
		check("disarmed", {7'h00, rv[2]}, 8'h00);
		do_reset(2'b11, 5'h00, 3'h7, 3'h3, 1'b0);
		wait_edges(20);
		clr(rv);
		check("open unarmed clear", rv, 8'h03);
		do_reset(2'b11, 5'h00, 3'h7, 3'h7, 1'b0);
		clr(rv);
		check("full window clear", rv, 8'h00);
		$display("test window done");
		close_out();
	end
endmodule : wwd_core_test
